// ==== rtl/oems_cfg.svh ====
`ifndef OEMS_CFG_SVH
`define OEMS_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_CHANNEL_ENABLE 8'h03
`define OFS_MOUNT_PIN      8'h04
`define OFS_SEQ_SLOT       8'h05

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CHAN_EN_MSB 3
`define CHAN_EN_LSB 1
`define PIN_DIAGNOSTIC_MODE_MSB    5
`define PIN_DIAGNOSTIC_MODE_LSB    4
`define PIN_MODE_MSB 3
`define SLOT_MSB    7
`define SLOT_LSB    2

// ---------------------------------------------------------------
// Encodings
// ---------------------------------------------------------------
`define PIN_DIAGNOSTIC_MODE_NORMAL   2'h0
`define PIN_DIAGNOSTIC_MODE_GND_SUP  2'h1
`define PIN_DIAGNOSTIC_MODE_SUP_GND  2'h2
`define MODE_OFF      2'h0
`define MODE_LOW_WET  2'h1
`define MODE_HIGH_WET 2'h2
`define MODE_DIVIDER  2'h3

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SLOT_UNIT_US  2440
`define CLK_PERIOD_NS 100
`define SLOT_UNIT_CYCLES ((`SLOT_UNIT_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== rtl/oems_pkg.sv ====
package oems_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_RUN  = 3'h2,
    SEQ_DONE = 3'h4
  } seq_state_t;
endpackage

// ==== rtl/slot_timer.sv ====
`timescale 1ns/100ps
module slot_timer #(
  parameter int unsigned BASE_CYCLES = 24400
) (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       run_in,
  input  wire logic [1:0] slot_period_sel_in,
  output logic            tick_out
);
  localparam int unsigned CW = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;

  logic [CW-1:0] base_cnt;
  logic [2:0]    scale_cnt;
  logic [3:0]    scale_span;
  logic [2:0]    scale_max;

  // Scale of 1, 2, 4 or 8 base periods
  assign scale_span = 4'h1 << slot_period_sel_in;
  assign scale_max  = 3'(scale_span - 4'h1);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !run_in) begin
      base_cnt  <= '0;
      scale_cnt <= 3'h0;
      tick_out  <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (base_cnt == CW'(BASE_CYCLES - 1)) begin
        base_cnt <= '0;
        if (scale_cnt >= scale_max) begin
          scale_cnt <= 3'h0;
          tick_out  <= 1'b1;
        end else begin
          scale_cnt <= scale_cnt + 3'h1;
        end
      end else begin
        base_cnt <= base_cnt + CW'(1);
      end
    end
  end
endmodule

// ==== rtl/oems_regs.sv ====
`timescale 1ns/100ps
`include "oems_cfg.svh"

// Behaviour
// - Channel enable register at 0x3, read/write, writes dropped while locked.
// - Diagnostic field 5:4 forces mount comparators: normal, gnd/sup, sup/gnd, reserved.
// - Pin mode fields 1:0 and 3:2: 00 all off, 01 low-side wetting.
// - Pin mode 10 high-side wetting only, 11 resistor divider only.
// - Slot fields at 0x5 bits 7:2, writes dropped while locked.
// - Lock bit set discards protected writes; clear allows all writes.
// - Output powers up after slot value times 2.44 ms times 2^period.
module oems_regs #(
  parameter int unsigned SLOT_CYCLES = `SLOT_UNIT_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       write_protect_bit_in,
  input  wire logic [1:0] slot_period_sel_in,
  input  wire logic [2:0] default_enable_in,
  input  wire logic [5:0] default_mount_in,
  input  wire logic [5:0] default_slot_in,
  input  wire logic       seq_start_in,
  output logic [7:0]      reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            out_b_enable_out,
  output logic            out_c_enable_out,
  output logic            out_d_enable_out,
  output logic [2:0]      power_up_out,
  output logic            seq_done_out,
  output logic            first_mount_pin_force_gnd_out,
  output logic            first_mount_pin_force_sup_out,
  output logic            second_mount_pin_force_gnd_out,
  output logic            second_mount_pin_force_sup_out,
  output logic [1:0]      low_wet_out,
  output logic [1:0]      high_wet_out,
  output logic [1:0]      divider_out
);
  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [2:0] chan_en;
  logic [5:0] mount_cfg;
  logic [5:0] slot_cfg;
  logic       wr_chan;
  logic       wr_mount;
  logic       wr_slot;
  logic [1:0] pin_diagnostic_mode;
  logic [1:0] pin_mode [2];

  assign wr_chan  = reg_wr_in && (reg_addr_in == `OFS_CHANNEL_ENABLE) && !write_protect_bit_in;
  assign wr_mount = reg_wr_in && (reg_addr_in == `OFS_MOUNT_PIN);
  assign wr_slot  = reg_wr_in && (reg_addr_in == `OFS_SEQ_SLOT) && !write_protect_bit_in;

  assign pin_diagnostic_mode = mount_cfg[`PIN_DIAGNOSTIC_MODE_MSB:`PIN_DIAGNOSTIC_MODE_LSB];
  assign pin_mode[0]         = mount_cfg[1:0];
  assign pin_mode[1]         = mount_cfg[`PIN_MODE_MSB:2];

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      chan_en <= default_enable_in;
    end else if (wr_chan) begin
      chan_en <= reg_wdata_in[`CHAN_EN_MSB:`CHAN_EN_LSB];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mount_cfg <= default_mount_in;
    end else if (wr_mount) begin
      mount_cfg <= reg_wdata_in[5:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      slot_cfg <= default_slot_in;
    end else if (wr_slot) begin
      slot_cfg <= reg_wdata_in[`SLOT_MSB:`SLOT_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `OFS_CHANNEL_ENABLE: reg_rdata_out <= {4'h0, chan_en, 1'b0};
          `OFS_MOUNT_PIN:      reg_rdata_out <= {2'h0, mount_cfg};
          `OFS_SEQ_SLOT:       reg_rdata_out <= {slot_cfg, 2'h0};
          default:             reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Mount pin decode
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      first_mount_pin_force_gnd_out  <= 1'b0;
      first_mount_pin_force_sup_out  <= 1'b0;
      second_mount_pin_force_gnd_out <= 1'b0;
      second_mount_pin_force_sup_out <= 1'b0;
    end else begin
      // Reserved code forces nothing
      first_mount_pin_force_gnd_out  <= (pin_diagnostic_mode == `PIN_DIAGNOSTIC_MODE_GND_SUP);
      second_mount_pin_force_sup_out <= (pin_diagnostic_mode == `PIN_DIAGNOSTIC_MODE_GND_SUP);
      first_mount_pin_force_sup_out  <= (pin_diagnostic_mode == `PIN_DIAGNOSTIC_MODE_SUP_GND);
      second_mount_pin_force_gnd_out <= (pin_diagnostic_mode == `PIN_DIAGNOSTIC_MODE_SUP_GND);
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        low_wet_out[p]  <= 1'b0;
        high_wet_out[p] <= 1'b0;
        divider_out[p]  <= 1'b0;
      end else begin
        low_wet_out[p]  <= (pin_mode[p] == `MODE_LOW_WET);
        high_wet_out[p] <= (pin_mode[p] == `MODE_HIGH_WET);
        divider_out[p]  <= (pin_mode[p] == `MODE_DIVIDER);
      end
    end
  end

  // ---------------------------------------------------------------
  // Enables and power-up sequencer
  // ---------------------------------------------------------------
  oems_pkg::seq_state_t state;
  logic [1:0] slot_count;
  logic       slot_tick;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      out_b_enable_out <= 1'b0;
      out_c_enable_out <= 1'b0;
      out_d_enable_out <= 1'b0;
    end else begin
      out_b_enable_out <= chan_en[0];
      out_c_enable_out <= chan_en[1];
      out_d_enable_out <= chan_en[2];
    end
  end

  slot_timer #(
    .BASE_CYCLES (SLOT_CYCLES)
  ) u_timer (
    .clock_in           (clock_in),
    .sys_rst_in         (sys_rst_in || seq_start_in),
    .run_in             (state == oems_pkg::SEQ_RUN),
    .slot_period_sel_in (slot_period_sel_in),
    .tick_out           (slot_tick)
  );

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state      <= oems_pkg::SEQ_IDLE;
      slot_count <= 2'h0;
    end else if (seq_start_in) begin
      state      <= oems_pkg::SEQ_RUN;
      slot_count <= 2'h0;
    end else begin
      case (state)
        oems_pkg::SEQ_IDLE: state <= oems_pkg::SEQ_IDLE;
        oems_pkg::SEQ_RUN: begin
          if (slot_tick) begin
            slot_count <= slot_count + 2'h1;
            if (slot_count == 2'h2) begin
              state <= oems_pkg::SEQ_DONE;
            end
          end
        end
        oems_pkg::SEQ_DONE: state <= oems_pkg::SEQ_DONE;
        default: state <= oems_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      seq_done_out <= 1'b0;
    end else begin
      seq_done_out <= (state == oems_pkg::SEQ_DONE);
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_out
    always_ff @(posedge clock_in) begin
      if (sys_rst_in || seq_start_in) begin
        power_up_out[i] <= 1'b0;
      end else begin
        case (state)
          oems_pkg::SEQ_RUN: begin
            power_up_out[i] <= chan_en[i] && (slot_cfg[2*i+:2] <= slot_count);
          end
          oems_pkg::SEQ_DONE: power_up_out[i] <= chan_en[i];
          default:            power_up_out[i] <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_locked_write(logic [7:0] ofs);
    reg_wr_in && write_protect_bit_in && (reg_addr_in == ofs);
  endsequence

  sequence s_open_write(logic [7:0] ofs);
    reg_wr_in && !write_protect_bit_in && (reg_addr_in == ofs);
  endsequence

  property p_chan_locked;
    s_locked_write(`OFS_CHANNEL_ENABLE) |=> $stable(chan_en);
  endproperty
  a_chan_locked: assert property (p_chan_locked) else $error("locked enable write took");

  property p_chan_open;
    s_open_write(`OFS_CHANNEL_ENABLE) |=> ##1 ({out_d_enable_out, out_c_enable_out,
      out_b_enable_out} == $past(reg_wdata_in[3:1], 2));
  endproperty
  a_chan_open: assert property (p_chan_open) else $error("enable write not seen");

  property p_slot_locked;
    s_locked_write(`OFS_SEQ_SLOT) |=> $stable(slot_cfg);
  endproperty
  a_slot_locked: assert property (p_slot_locked) else $error("locked slot write took");

  property p_pin_diagnostic_mode_gnd_sup;
    (pin_diagnostic_mode == `PIN_DIAGNOSTIC_MODE_GND_SUP) |=> first_mount_pin_force_gnd_out &&
      second_mount_pin_force_sup_out && !first_mount_pin_force_sup_out;
  endproperty
  a_pin_diagnostic_mode_gnd_sup: assert property (p_pin_diagnostic_mode_gnd_sup) else $error("pin_diagnostic_mode 01 wrong");

  property p_pin_diagnostic_mode_reserved;
    (pin_diagnostic_mode == 2'h3) |=> !first_mount_pin_force_gnd_out &&
      !first_mount_pin_force_sup_out && !second_mount_pin_force_gnd_out &&
      !second_mount_pin_force_sup_out;
  endproperty
  a_pin_diagnostic_mode_reserved: assert property (p_pin_diagnostic_mode_reserved) else $error("pin_diagnostic_mode 11 forces");

  property p_mode_low;
    (pin_mode[1] == `MODE_LOW_WET) |=> low_wet_out[1] && !high_wet_out[1] && !divider_out[1];
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("mode 01 wrong");

  property p_mode_div;
    (pin_mode[0] == `MODE_DIVIDER) |=> divider_out[0] && !low_wet_out[0] && !high_wet_out[0];
  endproperty
  a_mode_div: assert property (p_mode_div) else $error("mode 11 wrong");

  property p_pu_rise;
    $rose(power_up_out[0]) |-> $past(chan_en[0]) &&
      (($past(state) == oems_pkg::SEQ_DONE) || ($past(slot_cfg[1:0]) <= $past(slot_count)));
  endproperty
  a_pu_rise: assert property (p_pu_rise) else $error("output b early");

  property p_tick_step;
    (state == oems_pkg::SEQ_RUN) && slot_tick && !seq_start_in && (slot_count == 2'h1)
      |=> (slot_count == 2'h2);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("slot count stuck");
endmodule

// ==== dv/output_enable_mount_sequencer_cfg_test.sv ====
`timescale 1ns/100ps
module output_enable_mount_sequencer_cfg_test;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write_protect_bit;
    logic [7:0] exp;
  } row_t;

  logic       clock_in   = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       reg_wr_in  = 1'b0;
  logic       reg_rd_in  = 1'b0;
  logic [7:0] reg_addr_in  = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       write_protect_bit_in = 1'b0;
  logic [1:0] slot_period_sel_in   = 2'h1;
  logic       seq_start_in         = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       reg_rvalid_out;
  logic       out_b_enable_out;
  logic       out_c_enable_out;
  logic       out_d_enable_out;
  logic [2:0] power_up_out;
  logic       seq_done_out;
  logic       fg_out;
  logic       fs_out;
  logic       sg_out;
  logic       ss_out;
  logic [1:0] low_wet_out;
  logic [1:0] high_wet_out;
  logic [1:0] divider_out;
  int         n_errors;
  int         comparisons;
  int         t_up [3];
  logic [9:0] dec_exp;

  row_t rows [8] = '{
    '{8'h03, 8'hFF, 1'b0, 8'h0E}, '{8'h03, 8'h04, 1'b1, 8'h0E},
    '{8'h03, 8'h04, 1'b0, 8'h04}, '{8'h05, 8'hFF, 1'b0, 8'hFC},
    '{8'h05, 8'h00, 1'b1, 8'hFC}, '{8'h04, 8'h3F, 1'b1, 8'h3F},
    '{8'h04, 8'hC5, 1'b0, 8'h05}, '{8'h07, 8'h55, 1'b0, 8'h00}};

  always #50 clock_in = ~clock_in;

  oems_regs #(.SLOT_CYCLES(5)) u_oems_regs (
    .clock_in                       (clock_in),
    .sys_rst_in                     (sys_rst_in),
    .reg_wr_in                      (reg_wr_in),
    .reg_rd_in                      (reg_rd_in),
    .reg_addr_in                    (reg_addr_in),
    .reg_wdata_in                   (reg_wdata_in),
    .write_protect_bit_in           (write_protect_bit_in),
    .slot_period_sel_in             (slot_period_sel_in),
    .default_enable_in              (3'h5),
    .default_mount_in               (6'h1B),
    .default_slot_in                (6'h2D),
    .seq_start_in                   (seq_start_in),
    .reg_rdata_out                  (reg_rdata_out),
    .reg_rvalid_out                 (reg_rvalid_out),
    .out_b_enable_out               (out_b_enable_out),
    .out_c_enable_out               (out_c_enable_out),
    .out_d_enable_out               (out_d_enable_out),
    .power_up_out                   (power_up_out),
    .seq_done_out                   (seq_done_out),
    .first_mount_pin_force_gnd_out  (fg_out),
    .first_mount_pin_force_sup_out  (fs_out),
    .second_mount_pin_force_gnd_out (sg_out),
    .second_mount_pin_force_sup_out (ss_out),
    .low_wet_out                    (low_wet_out),
    .high_wet_out                   (high_wet_out),
    .divider_out                    (divider_out)
  );

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk({1'b1, reg_rdata_out}, {1'b1, exp});
    chk(reg_rvalid_out, 1'b1);
    @(posedge clock_in);
    #1;
    chk({reg_rvalid_out, reg_rdata_out}, {1'b0, exp});
  endtask

  task automatic run_seq();
    t_up = '{0, 0, 0};
    @(posedge clock_in);
    seq_start_in <= 1'b1;
    @(posedge clock_in);
    seq_start_in <= 1'b0;
    for (int n = 1; n <= 60; n++) begin
      @(posedge clock_in);
      #1;
      for (int k = 0; k < 3; k++)
        if (power_up_out[k] === 1'b1 && t_up[k] == 0)
          t_up[k] = n;
    end
  endtask

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_chk(8'h03, 8'h0A);
    rd_chk(8'h04, 8'h1B);
    rd_chk(8'h05, 8'hB4);
    chk({out_d_enable_out, out_c_enable_out, out_b_enable_out}, 3'h5);
    foreach (rows[i]) begin
      write_protect_bit_in <= rows[i].write_protect_bit;
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
      if (rows[i].addr == 8'h03)
        chk({out_d_enable_out, out_c_enable_out, out_b_enable_out}, rows[i].exp[3:1]);
    end
    write_protect_bit_in <= 1'b0;
    for (int v = 0; v < 64; v++) begin
      wr(8'h04, 8'(v));
      repeat (2) @(posedge clock_in);
      #1;
      dec_exp = {v[5:4] == 2'h1, v[5:4] == 2'h2, v[5:4] == 2'h2, v[5:4] == 2'h1,
                 v[3:2] == 2'h1, v[1:0] == 2'h1, v[3:2] == 2'h2, v[1:0] == 2'h2,
                 v[3:2] == 2'h3, v[1:0] == 2'h3};
      chk({fg_out, fs_out, sg_out, ss_out, low_wet_out, high_wet_out, divider_out},
          dec_exp);
    end
    // Slots b=0, c=1, d=3 at period setting 1: unit of 10 cycles
    wr(8'h03, 8'h0E);
    wr(8'h05, 8'hD0);
    run_seq();
    chk(t_up[0] == 1, 1'b1);
    chk(t_up[1] == 12, 1'b1);
    chk(t_up[2] == 32, 1'b1);
    chk(seq_done_out, 1'b1);
    wr(8'h03, 8'h00);
    repeat (3) @(posedge clock_in);
    #1;
    chk(power_up_out, 3'h0);
    @(posedge clock_in);
    seq_start_in <= 1'b1;
    @(posedge clock_in);
    seq_start_in <= 1'b0;
    repeat (40) @(posedge clock_in);
    #1;
    chk(power_up_out, 3'h0);
    // Slots b=2, c=0, d=1 at period setting 0: unit of 5 cycles
    wr(8'h03, 8'h0E);
    wr(8'h05, 8'h48);
    slot_period_sel_in <= 2'h0;
    run_seq();
    chk(t_up[0] == 12, 1'b1);
    chk(t_up[1] == 1, 1'b1);
    chk(t_up[2] == 7, 1'b1);
    chk(seq_done_out, 1'b1);
    // Reset after the run has completed restores factory values
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    chk({seq_done_out, reg_rvalid_out, power_up_out, out_d_enable_out, out_c_enable_out,
         out_b_enable_out}, 8'h00);
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd_chk(8'h03, 8'h0A);
    rd_chk(8'h04, 8'h1B);
    rd_chk(8'h05, 8'hB4);
    results();
  end
endmodule
